//--- logic/rsul_regs.sv
`timescale 1ns/10ps
`include "rsul_consts.svh"
// Functional notes
// - Status flag is 1 when latest conversion is at or above limit.
// - Seven-bit limit resets to zero; at-or-above sends assessment indication.
// - Seventh pin driven with inverted bit 7 only in card mode and enabled.
// - Reading bit 7 returns inverted seventh pin level always.
// - Five data bits drive pins only when enabled and interface strap is 1.
// - Reading the five data bits returns live pin levels.
// - Dummy register written only with zeros; reads may be undefined. This block returns 8'h00 on a read.
// - Seven-bit test command resets to zero and selects a test mode.
// - Comparison uses the converter result, unstable while conversion active.
module rsul_regs (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Register access
  input  wire rsul_pkg::rsul_req_s req,
  output logic [7:0]               rdata,
  output logic                     rvalid,
  // Converter and assessment
  input  wire rsul_pkg::rsul_conv_s conv,
  output logic                     cca_ind,
  // Configuration straps and enables
  input  wire rsul_pkg::rsul_mode_e if_mode,
  input  wire logic [4:0]          user_pin_drive_enable,
  input  wire logic                seventh_pin_drive_enable,
  // User pins
  input  wire logic [4:0]          user_pin_in,
  output logic [4:0]               user_pin_out,
  output logic [4:0]               user_pin_oe_n,
  input  wire logic                seventh_user_pin_in,
  output logic                     seventh_user_pin_out,
  output logic                     seventh_user_pin_oe_n,
  // Test mode select
  output logic [6:0]               test_command_field
);
  import rsul_pkg::*;

  rsul_state_s st_ff;
  rsul_state_s nxt_st;

  function automatic logic at_or_above(input logic [6:0] v,
                                       input logic [6:0] lim);
    at_or_above = (v >= lim);
  endfunction : at_or_above

  // ************************************************
  // Next state
  // ************************************************
  always_comb begin
    logic card;
    card   = (if_mode == RSUL_IF_PCCARD);
    nxt_st = st_ff;
    nxt_st.conv_prev = conv.active;
    // update at conversion end
    // Result is only trusted once the active bit has dropped
    if (st_ff.conv_prev && !conv.active) begin
      nxt_st.flag    = at_or_above(conv.result, st_ff.limit);
      nxt_st.cca_ind = at_or_above(conv.result, st_ff.limit);
    end
    nxt_st.rvalid = req.rd;
    nxt_st.rdata  = 8'h00;
    if (req.wr) begin
      case (req.idx)
        `RSUL_IDX_LIMIT: nxt_st.limit = req.wdata[6:0];
        `RSUL_IDX_USER: begin
          nxt_st.user_out    = req.wdata[4:0];
          nxt_st.seventh_out = ~req.wdata[`RSUL_SEVENTH_BIT];
        end
        // test register top bit forced zero
        `RSUL_IDX_TEST: nxt_st.test_cmd = req.wdata[6:0];
        default: nxt_st.test_cmd = st_ff.test_cmd;
      endcase
    end
    if (req.rd) begin
      case (req.idx)
        `RSUL_IDX_LIMIT: nxt_st.rdata = {st_ff.flag, st_ff.limit};
        `RSUL_IDX_USER: nxt_st.rdata = {~seventh_user_pin_in, 2'h0,
                                        user_pin_in};
        `RSUL_IDX_DUMMY: nxt_st.rdata = 8'h00;
        `RSUL_IDX_TEST: nxt_st.rdata = {1'b0, st_ff.test_cmd};
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    nxt_st.user_oe_n    = ~(user_pin_drive_enable & {5{card}});
    nxt_st.seventh_oe_n = ~(seventh_pin_drive_enable & card);
    if (rst) begin
      nxt_st = '0;
      nxt_st.limit     = `RSUL_LIMIT_RST;
      nxt_st.test_cmd  = `RSUL_TEST_RST;
      nxt_st.user_oe_n = 5'h1F;
      nxt_st.seventh_oe_n = 1'b1;
    end
  end

  // ************************************************
  // State register
  // ************************************************
  always_ff @(posedge core_clk) begin
    st_ff <= nxt_st;
  end

  // ************************************************
  // Outputs, all straight from the state register
  // ************************************************
  assign rdata                 = st_ff.rdata;
  assign rvalid                = st_ff.rvalid;
  assign cca_ind               = st_ff.cca_ind;
  assign user_pin_out          = st_ff.user_out;
  assign user_pin_oe_n         = st_ff.user_oe_n;
  assign seventh_user_pin_out  = st_ff.seventh_out;
  assign seventh_user_pin_oe_n = st_ff.seventh_oe_n;
  assign test_command_field    = st_ff.test_cmd;

  // ************************************************
  // Checks
  // ************************************************
  // Steps are spelled out as sequences so each property reads plainly
  sequence s_conv_end;
    $fell(conv.active);
  endsequence

  sequence s_limit_wr;
    req.wr && (req.idx == `RSUL_IDX_LIMIT);
  endsequence

  sequence s_limit_rd;
    req.rd && (req.idx == `RSUL_IDX_LIMIT);
  endsequence

  sequence s_user_wr;
    req.wr && (req.idx == `RSUL_IDX_USER);
  endsequence

  sequence s_user_rd;
    req.rd && (req.idx == `RSUL_IDX_USER);
  endsequence

  sequence s_test_rd;
    req.rd && (req.idx == `RSUL_IDX_TEST);
  endsequence

  sequence s_dummy_rd;
    req.rd && (req.idx == `RSUL_IDX_DUMMY);
  endsequence

  AST_FLAG_SET: assert property (
    @(posedge core_clk) disable iff (rst)
    s_conv_end ##0 (conv.result >= st_ff.limit) |=> st_ff.flag)
    else $error("flag not set at or above limit");
  AST_FLAG_CLR: assert property (
    @(posedge core_clk) disable iff (rst)
    s_conv_end ##0 (conv.result < st_ff.limit) |=> !st_ff.flag)
    else $error("flag not cleared below limit");
  AST_LIMIT_RD: assert property (
    @(posedge core_clk) disable iff (rst)
    s_limit_rd |=> rdata == {$past(st_ff.flag), $past(st_ff.limit)})
    else $error("limit readback wrong");

  AST_IND_MATCH: assert property (
    @(posedge core_clk) disable iff (rst)
    s_conv_end ##0 (conv.result >= st_ff.limit) |=> cca_ind)
    else $error("indication missing at or above limit");
  AST_IND_CLR: assert property (
    @(posedge core_clk) disable iff (rst)
    s_conv_end ##0 (conv.result < st_ff.limit) |=> !cca_ind)
    else $error("indication set below limit");
  AST_LIMIT_WR: assert property (
    @(posedge core_clk) disable iff (rst)
    s_limit_wr |=> st_ff.limit == $past(req.wdata[6:0]))
    else $error("limit field not written");

  AST_SEVENTH: assert property (
    @(posedge core_clk) disable iff (rst)
    s_user_wr |=> seventh_user_pin_out == ~$past(req.wdata[7]))
    else $error("seventh pin value wrong");
  AST_SEVENTH_KEEP: assert property (
    @(posedge core_clk) disable iff (rst)
    !(req.wr && req.idx == `RSUL_IDX_USER) |=>
      $stable(seventh_user_pin_out))
    else $error("seventh pin value moved without write");
  AST_SEVENTH_OE: assert property (
    @(posedge core_clk) disable iff (rst)
    if_mode != RSUL_IF_PCCARD |=> seventh_user_pin_oe_n)
    else $error("seventh pin driven outside card mode");
  AST_SEVENTH_ON: assert property (
    @(posedge core_clk) disable iff (rst)
    (if_mode == RSUL_IF_PCCARD) && seventh_pin_drive_enable |=>
      !seventh_user_pin_oe_n)
    else $error("seventh pin not driven when enabled");

  AST_RD7: assert property (
    @(posedge core_clk) disable iff (rst)
    s_user_rd |=> rvalid && rdata[7] == ~$past(seventh_user_pin_in))
    else $error("bit 7 readback wrong");

  AST_USER_OE: assert property (
    @(posedge core_clk) disable iff (rst)
    1'b1 |=> user_pin_oe_n == ~($past(user_pin_drive_enable) &
             {5{$past(if_mode) == RSUL_IF_PCCARD}}))
    else $error("user drive gating wrong");
  AST_USER_OUT: assert property (
    @(posedge core_clk) disable iff (rst)
    s_user_wr |=> user_pin_out == $past(req.wdata[4:0]))
    else $error("user pin data not stored");

  AST_RD_DATA: assert property (
    @(posedge core_clk) disable iff (rst)
    s_user_rd |=> rdata[4:0] == $past(user_pin_in))
    else $error("user readback wrong");

  // Dummy location reads zero so software never sees stale bus data
  AST_DUMMY_RD: assert property (
    @(posedge core_clk) disable iff (rst)
    s_dummy_rd |=> rvalid && rdata == 8'h00)
    else $error("dummy readback not zero");

  AST_TEST_TOP: assert property (
    @(posedge core_clk) disable iff (rst)
    s_test_rd |=> !rdata[7])
    else $error("test top bit not zero");
  AST_TEST_KEEP: assert property (
    @(posedge core_clk) disable iff (rst)
    !(req.wr && req.idx == `RSUL_IDX_TEST) |=>
      $stable(test_command_field))
    else $error("test command moved without write");

  // Result is unstable mid-conversion, so the flag must not follow it
  AST_BUSY_HOLD: assert property (
    @(posedge core_clk) disable iff (rst)
    conv.active |=> $stable(st_ff.flag) && $stable(cca_ind))
    else $error("flag moved during conversion");

  AST_HOLD: assert property (
    @(posedge core_clk) disable iff (rst)
    !$fell(conv.active) |=> $stable(st_ff.flag))
    else $error("flag moved without conversion end");
endmodule : rsul_regs

//--- logic/rsul_consts.svh
`ifndef RSUL_CONSTS_SVH
`define RSUL_CONSTS_SVH
// Register indices within the directly addressed group
`define RSUL_IDX_LIMIT      5'h1C
`define RSUL_IDX_USER       5'h1D
`define RSUL_IDX_DUMMY      5'h1E
`define RSUL_IDX_TEST       5'h1F
// Field positions
`define RSUL_FLAG_BIT       7
`define RSUL_SEVENTH_BIT    7
`define RSUL_TEST_TOP_BIT   7
// Reset values
`define RSUL_LIMIT_RST      7'h00
`define RSUL_TEST_RST       7'h00
`endif

//--- logic/rsul_pkg.sv
package rsul_pkg;
  // Register access request from the core or host side
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] idx;
    logic [7:0] wdata;
  } rsul_req_s;

  // Converter result as seen by the comparator
  typedef struct packed {
    logic       active;
    logic [6:0] result;
  } rsul_conv_s;

  typedef enum logic [0:0] {
    RSUL_IF_ISA,
    RSUL_IF_PCCARD
  } rsul_mode_e;

  // Whole state of the register group
  typedef struct packed {
    logic [6:0] limit;
    logic       flag;
    logic       cca_ind;
    logic       conv_prev;
    logic [4:0] user_out;
    logic       seventh_out;
    logic [4:0] user_oe_n;
    logic       seventh_oe_n;
    logic [6:0] test_cmd;
    logic [7:0] rdata;
    logic       rvalid;
  } rsul_state_s;
endpackage : rsul_pkg

//--- test/rsul_pin_model.sv
`timescale 1ns/10ps
// ****************
// Board-side pads
// ****************
module rsul_pin_model (
  // Pad drive from the block
  input  wire logic [5:0] drv,
  input  wire logic [5:0] oe_n,
  // Level the board pulls to
  input  wire logic [5:0] ext,
  // Resolved pad level
  output logic      [5:0] lvl
);
  // released pad level
  // A released pad shows the board level, so stale drive never reads back
  assign lvl = (drv & ~oe_n) | (ext & oe_n);
endmodule : rsul_pin_model

//--- test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import rsul_pkg::*;
  logic       core_clk, rst, cca_ind, rvalid, s_en, s_out, s_oe_n;
  logic [7:0] rdata;
  logic [4:0] en, u_out, u_oe_n;
  logic [5:0] ext, lvl;
  logic [6:0] tcmd;
  rsul_req_s  req;
  rsul_conv_s conv;
  rsul_mode_e mode;
  int         err_total, cmp_count, n;
  rsul_regs u_dut (.core_clk(core_clk), .rst(rst), .req(req),
    .rdata(rdata), .rvalid(rvalid), .conv(conv), .cca_ind(cca_ind),
    .if_mode(mode), .user_pin_drive_enable(en),
    .seventh_pin_drive_enable(s_en), .user_pin_in(lvl[4:0]),
    .user_pin_out(u_out), .user_pin_oe_n(u_oe_n),
    .seventh_user_pin_in(lvl[5]), .seventh_user_pin_out(s_out),
    .seventh_user_pin_oe_n(s_oe_n), .test_command_field(tcmd));
  rsul_pin_model u_pins (.drv({s_out, u_out}), .oe_n({s_oe_n, u_oe_n}),
    .ext(ext), .lvl(lvl));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // ****************
  // Access, check and verdict tasks
  // ****************
  task automatic give_verdict();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    req = '{1'b1, 1'b0, i, d};
    @(negedge core_clk);
    req.wr = 1'b0;
    @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [4:0] i, input logic [7:0] e);
    req = '{1'b0, 1'b1, i, 8'h00};
    @(negedge core_clk);
    req.rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    if (rvalid !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t read timed out", $time);
      give_verdict();
    end
    chk(rdata, e);
    @(negedge core_clk);
  endtask : rd
  // Result is applied with active high and held steady through and after the drop
  task automatic cv(input logic [6:0] r);
    conv = '{1'b1, r};
    @(negedge core_clk);
    conv.active = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : cv
  // ****************
  // Main sequence
  // ****************
  initial begin
    rst = 1'b1; req = '0; conv = '0; mode = RSUL_IF_ISA; en = 5'h1F;
    s_en = 1'b1; ext = 6'h2A; err_total = 0; cmp_count = 0;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    rd(5'h1C, 8'h00);
    rd(5'h1F, 8'h00);
    wr(5'h1C, 8'h40);
    cv(7'h40);
    rd(5'h1C, 8'hC0);
    chk({7'h00, cca_ind}, 8'h01);
    cv(7'h3F);
    rd(5'h1C, 8'h40);
    chk({7'h00, cca_ind}, 8'h00);
    cv(7'h7F);
    chk({7'h00, cca_ind}, 8'h01);
    wr(5'h1D, 8'h95);
    chk({2'b00, s_oe_n, u_oe_n}, 8'h3F);
    rd(5'h1D, 8'h0A);
    mode = RSUL_IF_PCCARD;
    repeat (2) @(negedge core_clk);
    chk({2'b00, s_oe_n, u_oe_n}, 8'h00);
    chk({2'b00, s_out, u_out}, 8'h15);
    rd(5'h1D, 8'h95);
    en = 5'h03;
    s_en = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({2'b00, s_oe_n, u_oe_n}, 8'h3C);
    rd(5'h1D, 8'h09);
    chk({1'b0, tcmd}, 8'h00);
    wr(5'h1E, 8'h00);
    rd(5'h1E, 8'h00);
    rd(5'h00, 8'h00);
    give_verdict();
  end
endmodule : testbench
